/* File: hdl/rtcv_pkg.sv */
// Constants shared by the calendar value register block
package rtcv_pkg;
  // ********************************************************
  // Register byte addresses
  // ********************************************************
  localparam logic [7:0] CTRL_ADDR      = 8'h00;
  localparam logic [7:0] ALARM_CFG_ADDR = 8'h04;
  localparam logic [7:0] TIME_WIN_ADDR  = 8'h08;
  localparam logic [7:0] ALARM_WIN_ADDR = 8'h0C;

  // ********************************************************
  // Control field positions
  // ********************************************************
  localparam int ENABLE_BIT = 15;
  localparam int WREN_BIT   = 13;
  localparam int HALF_BIT   = 11;
  localparam int PTR_LSB    = 8;

  // ********************************************************
  // Window pointer slots
  // ********************************************************
  localparam logic [1:0] SLOT_MIN_SEC  = 2'h0;
  localparam logic [1:0] SLOT_WEEKDAY_FIELD_HR  = 2'h1;
  localparam logic [1:0] SLOT_MONTH_DY = 2'h2;
  localparam logic [1:0] SLOT_YEAR     = 2'h3;
  localparam logic [1:0] PTR_RESET     = 2'h0;

  // ********************************************************
  // Implemented bits of each value register
  // ********************************************************
  localparam logic [15:0] YEAR_MASK = 16'h00FF;
  localparam logic [15:0] MD_MASK   = 16'h1F3F;
  localparam logic [15:0] WH_MASK   = 16'h073F;
  localparam logic [15:0] MS_MASK   = 16'h7F7F;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam longint SECOND_NS     = 1000000000;
  localparam longint CLK_PERIOD_NS = 100;
  localparam int     SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);
endpackage

/* File: hdl/rtcv_calendar_step.sv */
// One-second BCD calendar advance
`timescale 1ns/1ps
`default_nettype none
module rtcv_calendar_step (
  // Present time
  input  wire logic [15:0] year_value,
  input  wire logic [15:0] month_day_value,
  input  wire logic [15:0] weekday_hours_value,
  input  wire logic [15:0] minutes_seconds_value,
  // Time one second later
  output logic      [15:0] next_year,
  output logic      [15:0] next_month_day,
  output logic      [15:0] next_weekday_hours,
  output logic      [15:0] next_minutes_seconds
);
  logic [3:0] seconds_ones, minutes_ones, hours_ones, day_ones, month_ones, year_ones, year_tens;
  logic [2:0] seconds_tens, minutes_tens, weekday_field;
  logic [1:0] hours_tens, day_tens;
  logic       month_tens, leap, carry;
  logic [7:0] last_day;

  always_comb
  begin
    seconds_ones  = minutes_seconds_value[3:0];
    seconds_tens  = minutes_seconds_value[6:4];
    minutes_ones  = minutes_seconds_value[11:8];
    minutes_tens  = minutes_seconds_value[14:12];
    hours_ones    = weekday_hours_value[3:0];
    hours_tens    = weekday_hours_value[5:4];
    weekday_field = weekday_hours_value[10:8];
    day_ones      = month_day_value[3:0];
    day_tens      = month_day_value[5:4];
    month_ones    = month_day_value[11:8];
    month_tens    = month_day_value[12];
    year_ones     = year_value[3:0];
    year_tens     = year_value[7:4];
    // Two-digit year: multiple of four is a leap year
    leap = year_tens[0] ? (year_ones == 4'h2 || year_ones == 4'h6)
                        : (year_ones == 4'h0 || year_ones == 4'h4 || year_ones == 4'h8); // [RL17]
    unique case ({month_tens, month_ones})
      5'h02:                      last_day = leap ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_day = 8'h30;
      default:                    last_day = 8'h31;
    endcase
    carry = 1'b1;
    // Seconds, minutes, hours
    if (seconds_ones == 4'h9)
    begin
      seconds_ones = 4'h0;
      if (seconds_tens == 3'h5)
        seconds_tens = 3'h0;
      else
      begin
        seconds_tens = seconds_tens + 3'h1;
        carry = 1'b0;
      end
    end
    else
    begin
      seconds_ones = seconds_ones + 4'h1;
      carry = 1'b0;
    end
    if (carry)
    begin
      carry = 1'b0;
      if (minutes_ones != 4'h9)
        minutes_ones = minutes_ones + 4'h1;
      else
      begin
        minutes_ones = 4'h0;
        if (minutes_tens != 3'h5)
          minutes_tens = minutes_tens + 3'h1;
        else
        begin
          minutes_tens = 3'h0;
          carry = 1'b1;
        end
      end
    end
    if (carry)
    begin
      carry = 1'b0;
      if (hours_tens == 2'h2 && hours_ones == 4'h3)
      begin
        hours_tens = 2'h0;
        hours_ones = 4'h0;
        carry = 1'b1;
      end
      else if (hours_ones == 4'h9)
      begin
        hours_ones = 4'h0;
        hours_tens = hours_tens + 2'h1;
      end
      else
        hours_ones = hours_ones + 4'h1;
    end
    // Day, weekday, month, year
    if (carry)
    begin
      carry = 1'b0;
      weekday_field = (weekday_field >= 3'h6) ? 3'h0 : weekday_field + 3'h1;
      if ({2'h0, day_tens, day_ones} >= last_day)
      begin
        day_tens = 2'h0;
        day_ones = 4'h1;
        carry = 1'b1;
      end
      else if (day_ones == 4'h9)
      begin
        day_ones = 4'h0;
        day_tens = day_tens + 2'h1;
      end
      else
        day_ones = day_ones + 4'h1;
    end
    if (carry)
    begin
      carry = 1'b0;
      if (month_tens && month_ones >= 4'h2)
      begin
        month_tens = 1'b0;
        month_ones = 4'h1;
        carry = 1'b1;
      end
      else if (month_ones == 4'h9)
      begin
        month_ones = 4'h0;
        month_tens = 1'b1;
      end
      else
        month_ones = month_ones + 4'h1;
    end
    if (carry)
    begin
      if (year_ones != 4'h9)
        year_ones = year_ones + 4'h1;
      else
      begin
        year_ones = 4'h0;
        year_tens = (year_tens == 4'h9) ? 4'h0 : year_tens + 4'h1;
      end
    end
    next_year            = {8'h00, year_tens, year_ones};
    next_month_day       = {3'h0, month_tens, month_ones, 2'h0, day_tens, day_ones};
    next_weekday_hours   = {5'h00, weekday_field, 2'h0, hours_tens, hours_ones};
    next_minutes_seconds = {1'b0, minutes_tens, minutes_ones, 1'b0, seconds_tens, seconds_ones};
  end
endmodule
`default_nettype wire

/* File: hdl/rtcv_value_regs.sv */
// Calendar time and alarm value registers behind an APB slave
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
// ********************************************************
// Overview of operation
// ********************************************************
// Overview of operation
// RL1: Year tens bits 7-4, ones bits 3-0.
// RL2: Year writes only while write enable set.
// RL3: Month tens bit 12, ones bits 11-8.
// RL4: Day tens bits 5-4, ones 3-0.
// RL5: Weekday is bits 10-8, range 0-6.
// RL6: Hours tens bits 5-4, ones 3-0.
// RL7: Minutes tens bits 14-12, ones 11-8.
// RL8: Seconds tens bits 6-4, ones 3-0.
// RL9: Month/day, weekday/hours writes need write enable.
// RL10: Unused bits read zero, store nothing.
// RL11: Time counts in hardware; alarm only software.
// RL12: Digit fields have no reset value.
// RL13: Time pointer selects slot, decrements on upper.
// RL14: Alarm pointer selects slot, decrements on upper.
// RL15: Time window writes blocked without write enable.
// RL16: Minutes/seconds lower write clears half-second flag.
// RL17: Counter advances BCD calendar with leap years.
module rtcv_value_regs #(
  parameter int SECOND_CYCLES = rtcv_pkg::SECOND_CYCLES
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Status
  output logic             half_second_flag,
  output logic             second_tick
);
  localparam int PW = $clog2(SECOND_CYCLES + 1);
  localparam logic [PW-1:0] LAST_CYCLE = PW'(SECOND_CYCLES - 1);
  localparam logic [PW-1:0] HALF_CYCLE = PW'(SECOND_CYCLES / 2);

  // ********************************************************
  // Storage
  // ********************************************************
  logic        calendar_enable;
  logic        time_write_enable;
  logic [1:0]  time_window_pointer;
  logic [1:0]  alarm_window_pointer;
  logic [PW-1:0] prescale;
  // No reset on digit fields: software must load them first [RL12]
  logic [15:0] year_value;
  logic [15:0] month_day_value;
  logic [15:0] weekday_hours_value;
  logic [15:0] minutes_seconds_value;
  logic [15:0] alarm_month_day;
  logic [15:0] alarm_weekday_hours;
  logic [15:0] alarm_minutes_seconds;
  logic [15:0] next_year;
  logic [15:0] next_month_day;
  logic [15:0] next_weekday_hours;
  logic [15:0] next_minutes_seconds;

  // ********************************************************
  // Bus decode
  // ********************************************************
  logic        done;
  logic        hit_ctrl;
  logic        hit_acfg;
  logic        hit_time;
  logic        hit_alarm;
  logic        mapped;
  logic        time_wr;
  logic        alarm_wr;
  logic        time_upper_access;
  logic        alarm_upper_access;
  logic        ms_lower_write;
  logic [15:0] wdata;
  logic [15:0] lane_mask;
  logic [15:0] time_window;
  logic [15:0] alarm_window;
  logic [31:0] next_prdata;

  assign done      = psel && penable && pready;
  assign hit_ctrl  = (paddr == rtcv_pkg::CTRL_ADDR);
  assign hit_acfg  = (paddr == rtcv_pkg::ALARM_CFG_ADDR);
  assign hit_time  = (paddr == rtcv_pkg::TIME_WIN_ADDR);
  assign hit_alarm = (paddr == rtcv_pkg::ALARM_WIN_ADDR);
  assign mapped    = hit_ctrl || hit_acfg || hit_time || hit_alarm;
  assign wdata     = pwdata[15:0];
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  // Time window is locked while the write enable is clear [RL2] [RL9] [RL15]
  assign time_wr   = done && pwrite && hit_time && time_write_enable;
  // Alarm month/day and weekday/hours also need the write enable [RL9]
  assign alarm_wr  = done && pwrite && hit_alarm
                  && (time_write_enable || alarm_window_pointer == rtcv_pkg::SLOT_MIN_SEC);
  // A read covers both halves, so it counts as an upper access
  assign time_upper_access  = done && hit_time && (!pwrite || pstrb[1]); // [RL13]
  assign alarm_upper_access = done && hit_alarm && (!pwrite || pstrb[1]); // [RL14]
  assign ms_lower_write = time_wr && pstrb[0]
                       && time_window_pointer == rtcv_pkg::SLOT_MIN_SEC;

  // Byte-lane merge that never stores unused positions [RL10]
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] lanes,
                                        input logic [15:0] data, input logic [15:0] mask);
    merge = ((old & ~lanes) | (data & lanes)) & mask;
  endfunction

  // ********************************************************
  // Window read selection
  // ********************************************************
  always_comb
  begin
    unique case (time_window_pointer) // [RL13]
      rtcv_pkg::SLOT_MIN_SEC:  time_window = minutes_seconds_value & rtcv_pkg::MS_MASK;
      rtcv_pkg::SLOT_WEEKDAY_FIELD_HR:  time_window = weekday_hours_value & rtcv_pkg::WH_MASK;
      rtcv_pkg::SLOT_MONTH_DY: time_window = month_day_value & rtcv_pkg::MD_MASK;
      rtcv_pkg::SLOT_YEAR:     time_window = year_value & rtcv_pkg::YEAR_MASK; // [RL1]
    endcase
    unique case (alarm_window_pointer) // [RL14]
      rtcv_pkg::SLOT_MIN_SEC:  alarm_window = alarm_minutes_seconds & rtcv_pkg::MS_MASK;
      rtcv_pkg::SLOT_WEEKDAY_FIELD_HR:  alarm_window = alarm_weekday_hours & rtcv_pkg::WH_MASK;
      rtcv_pkg::SLOT_MONTH_DY: alarm_window = alarm_month_day & rtcv_pkg::MD_MASK;
      rtcv_pkg::SLOT_YEAR:     alarm_window = 16'h0000;
    endcase
    next_prdata = 32'h0000_0000;
    if (hit_ctrl)
    begin
      next_prdata[rtcv_pkg::ENABLE_BIT]             = calendar_enable;
      next_prdata[rtcv_pkg::WREN_BIT]               = time_write_enable;
      next_prdata[rtcv_pkg::HALF_BIT]               = half_second_flag;
      next_prdata[rtcv_pkg::PTR_LSB+1:rtcv_pkg::PTR_LSB] = time_window_pointer;
    end
    else if (hit_acfg)
      next_prdata[rtcv_pkg::PTR_LSB+1:rtcv_pkg::PTR_LSB] = alarm_window_pointer;
    else if (hit_time)
      next_prdata[15:0] = time_window;
    else if (hit_alarm)
      next_prdata[15:0] = alarm_window;
  end

  // ********************************************************
  // APB answer: one wait state per transfer
  // ********************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready && !pwrite)
        prdata <= next_prdata;
    end
  end

  // ********************************************************
  // Control and pointers
  // ********************************************************
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      calendar_enable     <= 1'b0;
      time_write_enable   <= 1'b0;
      time_window_pointer <= rtcv_pkg::PTR_RESET;
    end
    else if (done && pwrite && hit_ctrl && pstrb[1])
    begin
      time_write_enable   <= pwdata[rtcv_pkg::WREN_BIT];
      time_window_pointer <= pwdata[rtcv_pkg::PTR_LSB+1:rtcv_pkg::PTR_LSB];
      // The enable itself is guarded by the write enable
      if (time_write_enable)
        calendar_enable <= pwdata[rtcv_pkg::ENABLE_BIT];
    end
    else if (time_upper_access && time_window_pointer != 2'h0)
      time_window_pointer <= time_window_pointer - 2'h1; // [RL13]
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      alarm_window_pointer <= rtcv_pkg::PTR_RESET;
    else if (done && pwrite && hit_acfg && pstrb[1])
      alarm_window_pointer <= pwdata[rtcv_pkg::PTR_LSB+1:rtcv_pkg::PTR_LSB];
    else if (alarm_upper_access && alarm_window_pointer != 2'h0)
      alarm_window_pointer <= alarm_window_pointer - 2'h1; // [RL14]
  end

  // ********************************************************
  // Second prescaler and half-second flag
  // ********************************************************
  // Restarting the second on a seconds write keeps the flag and the count in step
  always_ff @(posedge core_clk)
  begin
    if (rst)
      prescale <= '0;
    else if (ms_lower_write || !calendar_enable)
      prescale <= '0; // [RL16]
    else if (prescale == LAST_CYCLE)
      prescale <= '0;
    else
      prescale <= prescale + PW'(1);
  end

  assign second_tick      = calendar_enable && !ms_lower_write && prescale == LAST_CYCLE;
  assign half_second_flag = prescale >= HALF_CYCLE; // [RL16]

  rtcv_calendar_step u_step (
    .year_value            (year_value),
    .month_day_value       (month_day_value),
    .weekday_hours_value   (weekday_hours_value),
    .minutes_seconds_value (minutes_seconds_value),
    .next_year             (next_year),
    .next_month_day        (next_month_day),
    .next_weekday_hours    (next_weekday_hours),
    .next_minutes_seconds  (next_minutes_seconds)
  );

  // ********************************************************
  // Time value registers: software write wins over the tick
  // ********************************************************
  always_ff @(posedge core_clk)
  begin
    if (time_wr && time_window_pointer == rtcv_pkg::SLOT_YEAR)
      year_value <= merge(year_value, lane_mask, wdata, rtcv_pkg::YEAR_MASK); // [RL1] [RL2]
    else if (second_tick)
      year_value <= next_year; // [RL11] [RL17]
  end

  always_ff @(posedge core_clk)
  begin
    if (time_wr && time_window_pointer == rtcv_pkg::SLOT_MONTH_DY)
      month_day_value <= merge(month_day_value, lane_mask, wdata, rtcv_pkg::MD_MASK); // [RL3] [RL4]
    else if (second_tick)
      month_day_value <= next_month_day; // [RL11]
  end

  always_ff @(posedge core_clk)
  begin
    if (time_wr && time_window_pointer == rtcv_pkg::SLOT_WEEKDAY_FIELD_HR)
      weekday_hours_value <= merge(weekday_hours_value, lane_mask, wdata, rtcv_pkg::WH_MASK); // [RL5] [RL6]
    else if (second_tick)
      weekday_hours_value <= next_weekday_hours; // [RL11]
  end

  always_ff @(posedge core_clk)
  begin
    if (time_wr && time_window_pointer == rtcv_pkg::SLOT_MIN_SEC)
      minutes_seconds_value <= merge(minutes_seconds_value, lane_mask, wdata, rtcv_pkg::MS_MASK); // [RL7] [RL8]
    else if (second_tick)
      minutes_seconds_value <= next_minutes_seconds; // [RL11]
  end

  // ********************************************************
  // Alarm value registers: software only
  // ********************************************************
  always_ff @(posedge core_clk)
  begin
    if (alarm_wr && alarm_window_pointer == rtcv_pkg::SLOT_MONTH_DY)
      alarm_month_day <= merge(alarm_month_day, lane_mask, wdata, rtcv_pkg::MD_MASK); // [RL3] [RL4] [RL9]
    if (alarm_wr && alarm_window_pointer == rtcv_pkg::SLOT_WEEKDAY_FIELD_HR)
      alarm_weekday_hours <= merge(alarm_weekday_hours, lane_mask, wdata, rtcv_pkg::WH_MASK); // [RL5] [RL6]
    if (alarm_wr && alarm_window_pointer == rtcv_pkg::SLOT_MIN_SEC)
      alarm_minutes_seconds <= merge(alarm_minutes_seconds, lane_mask, wdata, rtcv_pkg::MS_MASK); // [RL7] [RL8]
  end
endmodule
`default_nettype wire

/* File: bench/rtcv_value_regs_props.sv */
// Concurrent checks on the calendar value register block ports
`timescale 1ns/1ps
`default_nettype none
module rtcv_value_regs_props #(
  parameter int SECOND_CYCLES = 16
) (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Status
  input wire logic        half_second_flag,
  input wire logic        second_tick
);
  // Cycles from the half-second rise to the last prescaler count
  localparam int TICK_GAP = SECOND_CYCLES - SECOND_CYCLES / 2 - 1;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  chk_one_wait_state: assert property (psel && !penable |-> ##2 pready)
    else $error("ready not two cycles after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  chk_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  chk_upper_half_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("read data upper half not zero");
  chk_tick_restarts: assert property (second_tick |=> !half_second_flag)
    else $error("half flag high after tick");
  chk_half_to_tick: assert property ($rose(half_second_flag) ##TICK_GAP half_second_flag |-> second_tick)
    else $error("tick missing at end of second");
  chk_tick_after_half: assert property (second_tick |-> $past(half_second_flag) && !$past(second_tick))
    else $error("tick without a second half");

  cover property (pslverr);
  cover property (second_tick);
  cover property (pready && pwrite);
endmodule

bind rtcv_value_regs rtcv_value_regs_props #(.SECOND_CYCLES(SECOND_CYCLES)) rtcv_value_regs_props_inst (
  .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .half_second_flag(half_second_flag), .second_tick(second_tick));
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking testbench for the calendar value register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ********
  // Signals and model state
  // ********
  localparam int SC = 16;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  pstrb = 4'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        half_second_flag;
  logic        second_tick;
  logic [31:0] lfsr = 32'h89B3;
  logic [31:0] rd;
  logic        er;
  logic [15:0] tv [4];
  logic [15:0] av [4];
  int          en = 0, we = 0, tp = 0, ap = 0, n;
  int          n_fail = 0;
  int          samples_checked = 0;
  // Start and one-second-later values: year, month/day, weekday/hours, min/sec
  logic [15:0] cal_in [3][4] = '{'{16'h0099, 16'h1231, 16'h0623, 16'h5959},
    '{16'h0024, 16'h0228, 16'h0223, 16'h5959}, '{16'h0023, 16'h0228, 16'h0523, 16'h5959}};
  logic [15:0] cal_out [3][4] = '{'{16'h0000, 16'h0101, 16'h0000, 16'h0000},
    '{16'h0024, 16'h0229, 16'h0300, 16'h0000}, '{16'h0023, 16'h0301, 16'h0600, 16'h0000}};

  rtcv_value_regs #(.SECOND_CYCLES(SC)) rtcv_value_regs_inst (.core_clk(core_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .half_second_flag(half_second_flag),
    .second_tick(second_tick));

  initial
  begin
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [31:0] next_rnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] msk(input int slot);
    case (slot)
      3: return rtcv_pkg::YEAR_MASK;
      2: return rtcv_pkg::MD_MASK;
      1: return rtcv_pkg::WH_MASK;
      default: return rtcv_pkg::MS_MASK;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Request held until ready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int k;
    k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) n_fail++;
  endtask

  // One transfer, compared with the model, which is then updated
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] exp;
    logic [15:0] lm;
    logic        bad;
    lm = {{8{s[1]}}, {8{s[0]}}};
    bad = 1'b0;
    exp = 32'h0;
    case (a)
      rtcv_pkg::CTRL_ADDR: exp = 32'((en << 15) | (we << 13) | (tp << 8));
      rtcv_pkg::ALARM_CFG_ADDR: exp = 32'(ap << 8);
      rtcv_pkg::TIME_WIN_ADDR: exp = {16'h0, tv[tp]};
      rtcv_pkg::ALARM_WIN_ADDR: exp = {16'h0, av[ap]};
      default: bad = 1'b1;
    endcase
    apb(w, a, d, s);
    check({31'h0, er}, {31'h0, bad});
    if (!w) check(rd, exp);
    if (w && a == rtcv_pkg::CTRL_ADDR && s[1])
    begin
      if (we == 1) en = d[15];
      we = d[13];
      tp = d[9:8];
    end
    if (w && a == rtcv_pkg::ALARM_CFG_ADDR && s[1]) ap = d[9:8];
    if (w && a == rtcv_pkg::TIME_WIN_ADDR && we == 1) tv[tp] = ((tv[tp] & ~lm) | (d[15:0] & lm)) & msk(tp);
    if (w && a == rtcv_pkg::ALARM_WIN_ADDR && ap != 3 && (we == 1 || ap == 0))
      av[ap] = ((av[ap] & ~lm) | (d[15:0] & lm)) & msk(ap);
    if (a == rtcv_pkg::TIME_WIN_ADDR && (!w || s[1]) && tp > 0) tp--;
    if (a == rtcv_pkg::ALARM_WIN_ADDR && (!w || s[1]) && ap > 0) ap--;
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end

  initial
  begin
    av[3] = 16'h0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    // Reset state and refused addresses
    acc(1'b0, rtcv_pkg::CTRL_ADDR, 32'h0, 4'h0);
    acc(1'b0, rtcv_pkg::ALARM_CFG_ADDR, 32'h0, 4'h0);
    acc(1'b0, 8'h10, 32'h0, 4'h0);
    acc(1'b1, 8'hFC, 32'hFFFF, 4'hF);
    $display("test 1 done");
    // Random fills while unlocked, then while locked with partial lanes
    for (int r = 0; r < 2; r++)
      for (int p = 0; p < 2; p++)
      begin
        acc(1'b1, rtcv_pkg::CTRL_ADDR, r ? 32'h0300 : 32'h2300, 4'h2);
        acc(1'b1, rtcv_pkg::ALARM_CFG_ADDR, 32'h0300, 4'h2);
        for (int k = 0; k < 8; k++)
        begin
          lfsr = next_rnd(lfsr);
          acc(p == 0, k < 4 ? rtcv_pkg::TIME_WIN_ADDR : rtcv_pkg::ALARM_WIN_ADDR, lfsr,
            p ? 4'h0 : (r ? (lfsr[19:16] | 4'h2) : 4'hF));
        end
      end
    $display("test 2 done");
    // Lower min/sec write in the second half restarts the second
    acc(1'b1, rtcv_pkg::CTRL_ADDR, 32'h2000, 4'h2);
    acc(1'b1, rtcv_pkg::CTRL_ADDR, 32'hA000, 4'h2);
    n = 0;
    while (half_second_flag !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 40) n_fail++;
    acc(1'b1, rtcv_pkg::TIME_WIN_ADDR, 32'h0011, 4'h1);
    @(negedge core_clk);
    check({31'h0, half_second_flag}, 32'h0);
    acc(1'b0, rtcv_pkg::CTRL_ADDR, 32'h0, 4'h0);
    $display("test 3 done");
    // Calendar rollover, leap day and month end
    for (int c = 0; c < 3; c++)
    begin
      acc(1'b1, rtcv_pkg::CTRL_ADDR, 32'h2300, 4'h2);
      for (int k = 0; k < 4; k++) acc(1'b1, rtcv_pkg::TIME_WIN_ADDR, {16'h0, cal_in[c][k]}, 4'hF);
      acc(1'b1, rtcv_pkg::CTRL_ADDR, 32'hA000, 4'h2);
      n = 0;
      while (second_tick !== 1'b1 && n < 40)
      begin
        @(posedge core_clk);
        n++;
      end
      if (n >= 40) n_fail++;
      for (int k = 0; k < 4; k++) tv[3 - k] = cal_out[c][k];
      acc(1'b1, rtcv_pkg::CTRL_ADDR, 32'h2300, 4'h2);
      for (int k = 0; k < 4; k++) acc(1'b0, rtcv_pkg::TIME_WIN_ADDR, 32'h0, 4'h0);
    end
    acc(1'b1, rtcv_pkg::ALARM_CFG_ADDR, 32'h0300, 4'h2);
    for (int k = 0; k < 4; k++) acc(1'b0, rtcv_pkg::ALARM_WIN_ADDR, 32'h0, 4'h0);
    $display("test 4 done");
    wrap_up();
  end
endmodule
`default_nettype wire
